// [hw/touch_adc_serial_port.sv]
`timescale 1ns/1ps
`default_nettype none
module touch_adc_serial_port
    import touch_adc_pkg::*;
#(
    parameter int RESULT_W = 12
) (
    input wire logic clk, // System clock, 25 MHz.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic chip_select_n, // Chip select pin, active low.
    input wire logic shift_and_convert_clock, // Serial clock pin.
    input wire logic serial_in, // Serial data input pin.
    output logic serial_out, // Serial data output value.
    output logic serial_out_oe, // Serial data output enable.
    output logic busy_out, // Busy output value.
    output logic busy_out_oe, // Busy output enable.
    input wire logic sample_valid, // Converter sample present.
    output logic sample_ready, // Sample accepted into FIFO.
    input wire logic [RESULT_W-1:0] sample_data, // Converter sample word.
    output logic track_en, // Track-and-hold in tracking.
    output logic [2:0] channel_addr, // Selected channel address.
    output logic single_or_differential_select, // Single-ended when high.
    output logic addr_invalid // Address combination is invalid.
);
    import touch_adc_pkg::*;

    logic [1:0] cs_sync_reg, clk_sync_reg, din_sync_reg;
    logic sclk_prev_reg;
    logic rise, fall, sel;
    phase_t phase_reg;
    logic [3:0] cnt_reg;
    logic [CTRL_BITS-1:0] shift_reg;
    ctrl_word_t ctrl_reg;
    logic [RESULT_W+2:0] out_shift_reg;
    logic out_bit_reg, busy_reg, track_reg;
    logic fifo_valid;
    logic [RESULT_W-1:0] fifo_data;
    logic take;

    // Decode which result a control word returns.
    function automatic logic [1:0] addr_kind(input logic [2:0] a, input logic se);
        if (!se && a == ADDR_IN4)
            addr_kind = 2'h2;
        else if (a == ADDR_X || a == ADDR_Y)
            addr_kind = 2'h0;
        else if (se && (a == ADDR_IN3 || a == ADDR_IN4))
            addr_kind = 2'h0;
        else
            addr_kind = 2'h1;
    endfunction : addr_kind

    // Pins from the host pass two flip-flops before use.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cs_sync_reg <= 2'h3;
            clk_sync_reg <= 2'h0;
            din_sync_reg <= 2'h0;
            sclk_prev_reg <= 1'b0;
        end
        else
        begin
            cs_sync_reg <= {cs_sync_reg[0], chip_select_n};
            clk_sync_reg <= {clk_sync_reg[0], shift_and_convert_clock};
            din_sync_reg <= {din_sync_reg[0], serial_in};
            sclk_prev_reg <= clk_sync_reg[1];
        end
    end

    // Serial clock edges count only while selected.
    assign sel = !cs_sync_reg[1];
    assign rise = sel && clk_sync_reg[1] && !sclk_prev_reg;
    assign fall = sel && !clk_sync_reg[1] && sclk_prev_reg;

    // Sequence phases: command, acquisition, conversion.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
        end
        else if (!sel)
        begin
            phase_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
        end
        else
        begin
            unique case (phase_reg)
                ST_IDLE:
                begin
                    if (rise && din_sync_reg[1])
                    begin
                        phase_reg <= ST_CMD;
                        cnt_reg <= 4'h0;
                    end
                end
                ST_CMD:
                begin
                    if (fall)
                    begin
                        if (cnt_reg == 4'(ACQ_START_EDGE - 1))
                        begin
                            phase_reg <= ST_ACQ;
                            cnt_reg <= 4'h0;
                        end
                        else
                            cnt_reg <= cnt_reg + 4'h1;
                    end
                end
                ST_ACQ:
                begin
                    if (fall)
                    begin
                        if (cnt_reg == 4'(ACQ_CYCLES - 1))
                        begin
                            phase_reg <= ST_CONV;
                            cnt_reg <= 4'h0;
                        end
                        else
                            cnt_reg <= cnt_reg + 4'h1;
                    end
                end
                ST_CONV:
                begin
                    if (fall)
                    begin
                        if (cnt_reg == 4'(RESULT_W + 2))
                            phase_reg <= ST_IDLE;
                        else
                            cnt_reg <= cnt_reg + 4'h1;
                    end
                end
            endcase
        end
    end

    // Control bits shift in on rising edges, start bit first.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shift_reg <= '0;
            ctrl_reg <= '0;
        end
        else if (rise && phase_reg != ST_CONV)
        begin
            shift_reg <= {shift_reg[CTRL_BITS-2:0], din_sync_reg[1]};
            // The last control bit arrives during acquisition, before the hold edge reads it.
            if (phase_reg == ST_ACQ && cnt_reg == 4'(CTRL_BITS - ACQ_START_EDGE - 1))
                ctrl_reg <= ctrl_word_t'({shift_reg[CTRL_BITS-2:0], din_sync_reg[1]});
        end
    end

    // Result picked at the hold moment: sample, identity or invalid.
    assign take = fall && phase_reg == ST_ACQ && cnt_reg == 4'(ACQ_CYCLES - 1);
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            out_shift_reg <= '0;
        else if (take)
        begin
            unique case (addr_kind(ctrl_reg.addr, ctrl_reg.single_or_differential_select))
                2'h2: out_shift_reg <= {IDENT_CODE, 3'h0};
                2'h1: out_shift_reg <= {INVALID_CODE, 3'h0};
                default: out_shift_reg <= {(fifo_valid ? fifo_data : INVALID_CODE), 3'h0};
            endcase
        end
        else if (fall && phase_reg == ST_CONV)
            out_shift_reg <= {out_shift_reg[RESULT_W+1:0], 1'b0};
    end

    // Output bit and busy change on falling edges; deselect clears them.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_bit_reg <= 1'b0;
            busy_reg <= 1'b0;
            track_reg <= 1'b0;
        end
        else if (!sel)
        begin
            out_bit_reg <= 1'b0;
            busy_reg <= 1'b0;
            track_reg <= 1'b0;
        end
        else if (fall)
        begin
            track_reg <= (phase_reg == ST_CMD && cnt_reg == 4'(ACQ_START_EDGE - 1))
                || (phase_reg == ST_ACQ && cnt_reg != 4'(ACQ_CYCLES - 1));
            busy_reg <= take;
            if (take)
                out_bit_reg <= 1'b0;
            else if (phase_reg == ST_CONV)
                out_bit_reg <= out_shift_reg[RESULT_W+2];
            else
                out_bit_reg <= 1'b0;
        end
    end

    sample_fifo #(
        .WIDTH(RESULT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(sample_valid),
        .in_ready(sample_ready),
        .in_data(sample_data),
        .out_valid(fifo_valid),
        .out_ready(take && addr_kind(ctrl_reg.addr, ctrl_reg.single_or_differential_select) == 2'h0),
        .out_data(fifo_data)
    );

    // Drivers are enabled only while selected.
    assign serial_out = out_bit_reg;
    assign serial_out_oe = sel;
    assign busy_out = busy_reg;
    assign busy_out_oe = sel;
    assign track_en = track_reg;
    assign channel_addr = ctrl_reg.addr;
    assign single_or_differential_select = ctrl_reg.single_or_differential_select;
    assign addr_invalid = addr_kind(ctrl_reg.addr, ctrl_reg.single_or_differential_select) == 2'h1;
endmodule : touch_adc_serial_port
`default_nettype wire

// [hw/touch_adc_pkg.sv]
// Operation
// - Each serial input bit enters the control register on a rising serial clock edge; the code ignores serial input during conversion.
// - Result bits leave on the serial output, one per falling serial clock edge.
// - Serial data output is high impedance whenever chip select is high.
// - Busy output is high impedance while deselected, driven only while selected.
// - Active-low chip select enables the shift register and allows conversions.
// - The serial clock alone times transfer and conversion; host keeps it running.
// - Acquisition begins on the fifth falling edge after the start bit.
// - Exactly three serial clock cycles of acquisition precede the hold.
// - Channel address and single/differential bit select input; one code returns identity.
// - Result goes out MSB first, eleven more bits, then trailing zeros.
package touch_adc_pkg;
    localparam int CTRL_BITS = 8;
    localparam int RESULT_BITS = 12;
    localparam int ACQ_START_EDGE = 5;
    localparam int ACQ_CYCLES = 3;
    localparam int FIFO_DEPTH = 32;
    localparam logic [2:0] ADDR_X = 3'h1;
    localparam logic [2:0] ADDR_IN3 = 3'h2;
    localparam logic [2:0] ADDR_Y = 3'h5;
    localparam logic [2:0] ADDR_IN4 = 3'h6;
    // Identity code value is arbitrary.
    localparam logic [11:0] IDENT_CODE = 12'h5a5;
    localparam logic [11:0] INVALID_CODE = 12'h000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CMD = 2'b01,
        ST_ACQ = 2'b10,
        ST_CONV = 2'b11
    } phase_t;

    typedef struct packed {
        logic start;
        logic [2:0] addr;
        logic mode8;
        logic single_or_differential_select;
        logic [1:0] power_down;
    } ctrl_word_t;
endpackage : touch_adc_pkg

// [hw/sample_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 32
) (
    input wire logic clk, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic in_valid, // Write request.
    output logic in_ready, // Room available.
    input wire logic [WIDTH-1:0] in_data, // Write word.
    output logic out_valid, // Word available.
    input wire logic out_ready, // Read acknowledge.
    output logic [WIDTH-1:0] out_data // Head word.
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_reg, rd_reg;
    logic do_wr, do_rd;

    // Full and empty come from pointer comparison with a wrap bit.
    assign in_ready = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
    assign out_valid = wr_reg != rd_reg;
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;
    assign out_data = mem[rd_reg[AW-1:0]];

    // Storage array write.
    always_ff @(posedge clk)
    begin
        if (do_wr)
            mem[wr_reg[AW-1:0]] <= in_data;
    end

    // Pointer update.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_reg <= '0;
            rd_reg <= '0;
        end
        else
        begin
            if (do_wr)
                wr_reg <= wr_reg + 1'b1;
            if (do_rd)
                rd_reg <= rd_reg + 1'b1;
        end
    end
endmodule : sample_fifo
`default_nettype wire

// [verification/touch_adc_serial_port_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module touch_adc_serial_port_assertions
    import touch_adc_pkg::*;
(
    input wire logic clk, // Clock.
    input wire logic rst_n, // Reset.
    input wire logic chip_select_n, // Select.
    input wire logic serial_out_oe, // Data enable.
    input wire logic busy_out, // Busy.
    input wire logic busy_out_oe, // Busy enable.
    input wire logic track_en, // Tracking.
    input wire logic [2:0] channel_addr, // Channel.
    input wire logic single_or_differential_select, // Mode.
    input wire logic addr_invalid // Invalid.
);
    logic [5:0] trk_cnt_reg;
    logic addr_ok;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Counts the clock cycles spent tracking.
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) trk_cnt_reg <= 6'h00;
        else trk_cnt_reg <= track_en ? trk_cnt_reg + 6'h01 : 6'h00;
    // Listed address and mode combinations.
    assign addr_ok = (channel_addr == ADDR_X) || (channel_addr == ADDR_Y)
        || (channel_addr == ADDR_IN4) || (single_or_differential_select && channel_addr == ADDR_IN3);
    chk_dout_hiz: assert property (chip_select_n [*4] |-> !serial_out_oe)
        else $error("Data output driven while deselected.");
    chk_busy_hiz: assert property (chip_select_n [*4] |-> !busy_out_oe)
        else $error("Busy driven while deselected.");
    chk_oe_pair: assert property (serial_out_oe == busy_out_oe)
        else $error("Output enables differ.");
    chk_cs_enable: assert property (!chip_select_n [*5] |-> serial_out_oe)
        else $error("Outputs not driven while selected.");
    chk_idle_quiet: assert property (chip_select_n [*5] |-> !track_en && !busy_out)
        else $error("Activity while deselected.");
    chk_track_len: assert property ($fell(track_en) |-> trk_cnt_reg >= 6'h17 && trk_cnt_reg <= 6'h19)
        else $error("Acquisition length wrong.");
    chk_busy_follow: assert property ($fell(track_en) |-> ##[0:1] busy_out)
        else $error("Busy missing after hold.");
    chk_busy_len: assert property ($rose(busy_out) |-> busy_out [*8] ##[1:2] !busy_out)
        else $error("Busy length wrong.");
    chk_addr_decode: assert property (addr_invalid == !addr_ok)
        else $error("Address validity wrong.");
endmodule : touch_adc_serial_port_assertions
`default_nettype wire

// [verification/touch_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module touch_host_model (
    input wire logic clk, // Clock.
    output logic cs_n, // Select, active low.
    output logic sclk, // Serial clock.
    output logic din, // Data to device.
    input wire logic dout, // Data from device.
    input wire logic dout_oe, // Data enable.
    input wire logic trk, // Tracking.
    input wire logic bsy, // Busy.
    output logic res_valid, // Trace ready.
    output logic [63:0] res // Trace.
);
    // Idle bus: deselected, clock standing low.
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
        res_valid = 1'b0;
        res = 64'h0;
    end
    // Waits k cycles, then steps off the edge.
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    // One frame of n serial clocks; traces are sampled late in each high half.
    task automatic xfer(input logic [7:0] ctrl, input int n);
        logic [63:0] r;
        r = {1'b1, 63'h0};
        cs_n = 1'b0;
        tick(4);
        for (int i = 1; i <= n; i++)
        begin
            din = (i <= 8) ? ctrl[8 - i] : 1'b0;
            tick(4);
            sclk = 1'b1;
            tick(4);
            r[63] = r[63] & dout_oe;
            r[38 + i] = bsy;
            r[14 + i] = trk;
            if (i >= 10) r[24 - i] = dout;
            sclk = 1'b0;
        end
        tick(4);
        cs_n = 1'b1;
        res = r;
        res_valid = (n == 24);
        tick(1);
        res_valid = 1'b0;
        tick(6);
    endtask : xfer
endmodule : touch_host_model
`default_nettype wire

// [verification/touch_adc_serial_port_test.sv]
`timescale 1ns/1ps
`default_nettype none
module touch_adc_serial_port_test;
    import touch_adc_pkg::*;
    logic clk, rst_n, cs_n, sclk, din, dout, dout_pin, dout_oe, bsy, bsy_oe, trk;
    logic s_valid, s_ready, inval, sel, res_valid;
    logic [11:0] s_data;
    logic [2:0] addr;
    logic [63:0] res;
    logic [63:0] exp_q[$];
    logic [11:0] fifo_q[$];
    int error_cnt, total_checks;
    // Released data line shows the opposite level.
    assign dout_pin = dout_oe ? dout : !dout;
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    touch_adc_serial_port u_dut (.clk(clk), .rst_n(rst_n), .chip_select_n(cs_n),
        .shift_and_convert_clock(sclk), .serial_in(din), .serial_out(dout),
        .serial_out_oe(dout_oe), .busy_out(bsy), .busy_out_oe(bsy_oe), .sample_valid(s_valid),
        .sample_ready(s_ready), .sample_data(s_data), .track_en(trk), .channel_addr(addr),
        .single_or_differential_select(sel), .addr_invalid(inval));
    touch_host_model u_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout_pin),
        .dout_oe(dout_oe), .trk(trk), .bsy(bsy), .res_valid(res_valid), .res(res));
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test
    // One conversion: notes the expected trace of a 24-clock frame, runs the frame, checks the decode.
    task automatic conv(input logic [2:0] a, input logic s, input int n);
        logic [11:0] d;
        logic ok;
        ok = (a == ADDR_X) || (a == ADDR_Y) || (a == ADDR_IN4) || (s && a == ADDR_IN3);
        d = 12'h000;
        if (a == ADDR_IN4 && !s) d = IDENT_CODE;
        else if (ok && fifo_q.size() > 0) d = fifo_q.pop_front();
        if (n == 24) exp_q.push_back({1'b1, 24'h000100, 24'h0000e0, d, 3'h0});
        u_host.xfer({1'b1, a, 1'b0, s, 2'h0}, n);
        check("addr", {61'h0, addr}, {61'h0, a});
        check("mode", {63'h0, sel}, {63'h0, s});
        check("invalid", {63'h0, inval}, {63'h0, !ok});
    endtask : conv
    // Compares each captured trace with the oldest note.
    always @(posedge clk)
        if (res_valid === 1'b1)
        begin
            if (exp_q.size() == 0) check("extra", 64'h1, 64'h0);
            else check("trace", res, exp_q.pop_front());
        end
    initial
    begin
        rst_n = 1'b0;
        s_valid = 1'b0;
        s_data = 12'h000;
        void'($urandom(32'h4c3f4d4b));
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        // Every address and mode code with an empty buffer.
        for (int k = 0; k < 16; k++) conv(k[3:1], k[0], 24);
        // Fills the buffer until it refuses a word.
        for (int k = 0; k < 33; k++)
        begin
            s_data = 12'($urandom);
            s_valid = 1'b1;
            if (s_ready === 1'b1) fifo_q.push_back(s_data);
            @(posedge clk);
            #1;
        end
        s_valid = 1'b0;
        check("full", {63'h0, s_ready}, 64'h0);
        check("fill", 64'(fifo_q.size()), 64'h20);
        // Frame cut short while the result shifts out.
        conv(ADDR_Y, 1'b1, 12);
        // Drains the buffer and converts once more when empty.
        for (int k = 0; k < 32; k++) conv(k[1] ? ADDR_Y : ADDR_X, k[0], 24);
        for (int k = 0; k < 100 && exp_q.size() > 0; k++) @(posedge clk);
        if (exp_q.size() > 0) error_cnt++;
        stop_test();
    end
    // Cuts a hang short.
    initial
    begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        stop_test();
    end
endmodule : touch_adc_serial_port_test
bind touch_adc_serial_port touch_adc_serial_port_assertions u_chk (.clk(clk), .rst_n(rst_n),
    .chip_select_n(chip_select_n), .serial_out_oe(serial_out_oe), .busy_out(busy_out),
    .busy_out_oe(busy_out_oe), .track_en(track_en), .channel_addr(channel_addr),
    .single_or_differential_select(single_or_differential_select), .addr_invalid(addr_invalid));
`default_nettype wire
